// file: design/pcie_slot_cap_ctl_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Thirteen-bit slot number, upper bits, resets zero
// - Scale codes 1.0, 0.1, 0.01, 0.001
// - Value times scale gives slot watts
// - First write of value or scale sends limit message; later writes are ignored
// - Interlock-present flag reads zero
// - Power-light-present flag reads zero
// - Attention-light-present flag reads zero
// - Latch-sensor-present flag reads zero
// - Power-controller-present flag reads zero
// - Attention-button-present flag reads zero
// - Link-state notify enable gates notification
// - Without link reporting, enable hardwired zero
// - Interlock write one toggles, zero ignored
// - Interlock control bit always reads zero
// - Power control: zero on, one off
// - Power control reads last written value; here it reads zero, as no controller is fitted
// - Controller may cut power on fault
// - No controller: power control writes ignored
module pcie_slot_cap_ctl_regs
    import slot_regs_pkg::*;
#(
    parameter bit has_power_controller = 1'b0,
    parameter bit has_interlock = 1'b0
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic power_fault,
    input wire logic link_active_change,
    output logic power_limit_msg,
    output logic [7:0] power_limit_value,
    output logic [1:0] power_limit_scale,
    output logic slot_power_on,
    output logic interlock_toggle,
    output logic link_state_notify
);
    // This port has neither fitting; refuse a build that asks for one
    if (has_power_controller || has_interlock) begin : g_unsupported
        $error("Controller and interlock are not fitted on this port");
    end

    logic [31:0] cap_value;
    logic [15:0] ctl_value;
    logic [slot_number_width-1:0] physical_slot_number;
    logic number_locked;
    logic limit_locked;
    logic slot_power_control;
    logic fault_sync1;
    logic fault_sync2;
    logic link_sync1;
    logic link_sync2;

    wire cap_sel = cfg_addr == slot_capabilities_offset;
    wire ctl_sel = cfg_addr == slot_control_offset;
    wire cap_wr = cfg_wr && cap_sel;
    wire ctl_wr = cfg_wr && ctl_sel;
    // Slot number spans bytes 2 and 3; limit fields span bytes 0..2
    wire number_wr = cap_wr && (cfg_be[3] || cfg_be[2]) && !number_locked;
    wire limit_wr = cap_wr && (cfg_be[2] || cfg_be[1] || cfg_be[0]) && !limit_locked;
    wire ctl_hi_wr = ctl_wr && cfg_be[1];
    wire link_notify_en = 1'b0;
    wire [31:0] be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};
    wire [31:0] cap_merged = (cfg_wdata & be_mask) | (cap_value & ~be_mask);

    always_comb begin
        cap_value = 32'h0000_0000;
        cap_value[slot_number_lsb +: slot_number_width] = physical_slot_number;
        cap_value[reserved_one_bit] = 1'b1;
        cap_value[interlock_present_bit] = 1'b0;
        cap_value[limit_scale_lsb +: limit_scale_width] = power_limit_scale;
        cap_value[limit_value_lsb +: limit_value_width] = power_limit_value;
        cap_value[power_light_present_bit] = 1'b0;
        cap_value[attention_light_present_bit] = 1'b0;
        cap_value[latch_sensor_present_bit] = 1'b0;
        cap_value[power_ctrl_present_bit] = has_power_controller;
        cap_value[attention_button_present_bit] = 1'b0;
    end

    always_comb begin
        ctl_value = slot_control_reset;
        ctl_value[link_notify_en_bit] = link_notify_en;
        ctl_value[interlock_toggle_bit] = 1'b0;
        // Undefined when no controller; zero is the simplest defined answer
        ctl_value[slot_power_control_bit] = has_power_controller && slot_power_control;
    end

    // Unmapped offsets read zero so probing software sees no stale data
    wire [31:0] ctl_word = {16'h0000, ctl_value};
    wire [31:0] ctl_or_zero = ctl_sel ? ctl_word : 32'h0000_0000;
    wire [31:0] read_mux = cap_sel ? cap_value : ctl_or_zero;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_rd) begin
            cfg_rdata <= read_mux;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            physical_slot_number <= '0;
            number_locked <= 1'b0;
        end else if (number_wr) begin
            physical_slot_number <= cap_merged[slot_number_lsb +: slot_number_width];
            number_locked <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_limit_value <= 8'h00;
            power_limit_scale <= scale_x1;
            limit_locked <= 1'b0;
            power_limit_msg <= 1'b0;
        end else begin
            power_limit_msg <= limit_wr;
            if (limit_wr) begin
                power_limit_value <= cap_merged[limit_value_lsb +: limit_value_width];
                power_limit_scale <= cap_merged[limit_scale_lsb +: limit_scale_width];
                limit_locked <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fault_sync1 <= 1'b0;
            fault_sync2 <= 1'b0;
            link_sync1 <= 1'b0;
            link_sync2 <= 1'b0;
        end else begin
            fault_sync1 <= power_fault;
            fault_sync2 <= fault_sync1;
            link_sync1 <= link_active_change;
            link_sync2 <= link_sync1;
        end
    end

    // Power control bit; without a controller writes are dropped
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            slot_power_control <= 1'b0;
        end else if (ctl_hi_wr && has_power_controller) begin
            slot_power_control <= cfg_wdata[slot_power_control_bit];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            slot_power_on <= 1'b0;
            interlock_toggle <= 1'b0;
            link_state_notify <= 1'b0;
        end else begin
            // A fault removes power whatever the control bit says
            slot_power_on <= has_power_controller && !slot_power_control && !fault_sync2;
            interlock_toggle <= has_interlock && ctl_hi_wr && cfg_wdata[interlock_toggle_bit];
            link_state_notify <= link_notify_en && link_sync2;
        end
    end

    // Steps of a limit write and of a register read
    sequence limit_write_seen;
        limit_wr;
    endsequence

    sequence msg_one_cycle;
        power_limit_msg ##1 !power_limit_msg;
    endsequence

    sequence cap_read;
        cfg_rd && cap_sel;
    endsequence

    sequence ctl_read;
        cfg_rd && ctl_sel;
    endsequence

    sequence unmapped_read;
        cfg_rd && !cap_sel && !ctl_sel;
    endsequence

    chk_limit_msg_pulse: assert property (@(posedge clk) disable iff (!rstn)
        limit_wr |=> power_limit_msg)
        else $error("limit write did not send message");

    chk_limit_once: assert property (@(posedge clk) disable iff (!rstn)
        limit_locked |=> $stable(power_limit_value) && $stable(power_limit_scale))
        else $error("locked limit changed");

    chk_number_once: assert property (@(posedge clk) disable iff (!rstn)
        number_locked |=> $stable(physical_slot_number))
        else $error("locked slot number changed");

    chk_no_msg_locked: assert property (@(posedge clk) disable iff (!rstn)
        limit_locked && $past(limit_locked) |-> !power_limit_msg)
        else $error("message sent after lock");

    chk_cap_flags: assert property (@(posedge clk) disable iff (!rstn)
        cap_value[17] == 1'b0 && cap_value[4:0] == 5'h00 && cap_value[18])
        else $error("capability flags wrong");

    chk_ctl_read_zero: assert property (@(posedge clk) disable iff (!rstn)
        ctl_value[12:11] == 2'b00)
        else $error("interlock or notify bit reads nonzero");

    chk_power_off: assert property (@(posedge clk) disable iff (!rstn)
        !slot_power_on && !interlock_toggle)
        else $error("absent controller drives slot");

    chk_read_number: assert property (@(posedge clk) disable iff (!rstn)
        cfg_rd && cap_sel |=> cfg_rdata[31:19] == $past(physical_slot_number))
        else $error("slot number read mismatch");

    chk_no_notify: assert property (@(posedge clk) disable iff (!rstn)
        link_sync2 |=> !link_state_notify)
        else $error("notify raised while disabled");

    chk_msg_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
        limit_write_seen |=> msg_one_cycle)
        else $error("limit message not a single pulse");

    chk_msg_needs_write: assert property (@(posedge clk) disable iff (!rstn)
        power_limit_msg |->
        $past(limit_wr))
        else $error("limit message without a write");

    chk_value_load: assert property (@(posedge clk) disable iff (!rstn)
        limit_wr |=>
        power_limit_value == $past(cap_merged[limit_value_lsb +: limit_value_width]))
        else $error("limit value not taken from write");

    chk_scale_load: assert property (@(posedge clk) disable iff (!rstn)
        limit_wr |=>
        power_limit_scale == $past(cap_merged[limit_scale_lsb +: limit_scale_width]))
        else $error("limit scale not taken from write");

    chk_number_load: assert property (@(posedge clk) disable iff (!rstn)
        number_wr |=>
        physical_slot_number == $past(cap_merged[slot_number_lsb +: slot_number_width]))
        else $error("slot number not taken from write");

    chk_number_lock_set: assert property (@(posedge clk) disable iff (!rstn)
        number_wr |=>
        number_locked)
        else $error("slot number not locked after write");

    chk_limit_lock_set: assert property (@(posedge clk) disable iff (!rstn)
        limit_wr |=>
        limit_locked)
        else $error("limit fields not locked after write");

    // Only reset may open a lock again
    chk_locks_stay: assert property (@(posedge clk) disable iff (!rstn)
        number_locked || limit_locked |=>
        $stable(number_locked) && $stable(limit_locked))
        else $error("write-once lock released");

    chk_read_ctl: assert property (@(posedge clk) disable iff (!rstn)
        ctl_read |=>
        cfg_rdata == {16'h0000, $past(ctl_value)})
        else $error("control read mismatch");

    chk_read_ctl_hi: assert property (@(posedge clk) disable iff (!rstn)
        ctl_read |=>
        cfg_rdata[31:11] == 21'h00_0000)
        else $error("control read upper bits nonzero");

    chk_read_unmapped: assert property (@(posedge clk) disable iff (!rstn)
        unmapped_read |=>
        cfg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    chk_read_cap_flags: assert property (@(posedge clk) disable iff (!rstn)
        cap_read |=>
        cfg_rdata[18:17] == 2'b10)
        else $error("interlock flag read wrong");

    chk_read_low_flags: assert property (@(posedge clk) disable iff (!rstn)
        cap_read |=>
        cfg_rdata[6:0] == 7'h00)
        else $error("presence flags read nonzero");

    chk_read_limit: assert property (@(posedge clk) disable iff (!rstn)
        cap_read |=>
        cfg_rdata[16:7] == {$past(power_limit_scale), $past(power_limit_value)})
        else $error("limit fields read mismatch");

    // Read data stands between reads so slow software may sample late
    chk_read_hold: assert property (@(posedge clk) disable iff (!rstn)
        !cfg_rd |=>
        $stable(cfg_rdata))
        else $error("read data changed without read");

    chk_scale_reads_back: assert property (@(posedge clk) disable iff (!rstn)
        cap_value[limit_scale_lsb +: limit_scale_width] == power_limit_scale)
        else $error("scale field not shown in register");

    chk_power_bit_zero: assert property (@(posedge clk) disable iff (!rstn)
        ctl_value[slot_power_control_bit] == 1'b0)
        else $error("power control bit reads nonzero");

    chk_ctl_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
        ctl_value[15:13] == 3'h0)
        else $error("control reserved bits nonzero");

    chk_interlock_quiet: assert property (@(posedge clk) disable iff (!rstn)
        !ctl_hi_wr |=>
        !interlock_toggle)
        else $error("interlock pulse without write");

    chk_fault_cuts_power: assert property (@(posedge clk) disable iff (!rstn)
        fault_sync2 |=>
        !slot_power_on)
        else $error("power stays on during fault");

    chk_notify_never: assert property (@(posedge clk) disable iff (!rstn)
        !link_state_notify)
        else $error("link notify raised");
endmodule

// file: design/slot_regs_pkg.sv
package slot_regs_pkg;
    localparam logic [7:0] slot_capabilities_offset = 8'hb4;
    localparam logic [7:0] slot_control_offset = 8'hb8;
    localparam logic [31:0] slot_capabilities_reset = 32'h0004_0000;
    localparam logic [15:0] slot_control_reset = 16'h0000;
    localparam int slot_number_lsb = 19;
    localparam int slot_number_width = 13;
    localparam int reserved_one_bit = 18;
    localparam int interlock_present_bit = 17;
    localparam int limit_scale_lsb = 15;
    localparam int limit_scale_width = 2;
    localparam int limit_value_lsb = 7;
    localparam int limit_value_width = 8;
    localparam int power_light_present_bit = 4;
    localparam int attention_light_present_bit = 3;
    localparam int latch_sensor_present_bit = 2;
    localparam int power_ctrl_present_bit = 1;
    localparam int attention_button_present_bit = 0;
    localparam int link_notify_en_bit = 12;
    localparam int interlock_toggle_bit = 11;
    localparam int slot_power_control_bit = 10;
    // Scale encodings: multiplier of the power limit value
    localparam logic [1:0] scale_x1 = 2'h0;
    localparam logic [1:0] scale_x0p1 = 2'h1;
    localparam logic [1:0] scale_x0p01 = 2'h2;
    localparam logic [1:0] scale_x0p001 = 2'h3;
endpackage

// file: verification/pcie_slot_cap_ctl_regs_tb_top.sv
`timescale 1ns/1ps
module pcie_slot_cap_ctl_regs_tb_top;
    import slot_regs_pkg::*;
    logic clk, rstn, cfg_wr, cfg_rd, fault_req;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, exp_caps;
    logic power_fault, link_active_change, power_limit_msg;
    logic [7:0] power_limit_value;
    logic [1:0] power_limit_scale;
    logic slot_power_on, interlock_toggle, link_state_notify;
    int msg_count, err_count = 0, compares = 0, cycles = 0;
    pcie_slot_cap_ctl_regs uut (.clk(clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .power_fault(power_fault), .link_active_change(link_active_change),
        .power_limit_msg(power_limit_msg), .power_limit_value(power_limit_value),
        .power_limit_scale(power_limit_scale), .slot_power_on(slot_power_on),
        .interlock_toggle(interlock_toggle), .link_state_notify(link_state_notify));
    slot_partner partner (.clk(clk), .rstn(rstn), .power_limit_msg(power_limit_msg),
        .fault_req(fault_req), .power_fault(power_fault),
        .link_active_change(link_active_change), .msg_count(msg_count));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task tally_and_finish;
        $display("compares=%0d err_count=%0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cfg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= 4'hf;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
    endtask
    task cfg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        @(posedge clk);
        #1 check(cfg_rdata, exp);
    endtask
    task reset_values;
        cfg_read(slot_capabilities_offset, 32'h0004_0000);
        cfg_read(slot_control_offset, 32'h0000_0000);
        cfg_read(8'hc0, 32'h0000_0000);
    endtask
    task limit_write_once;
        // Low flag bits written as ones must still read zero
        exp_caps = (32'h1abc << 19) | (32'h1 << 18) | (32'h3 << 15) | (32'ha5 << 7);
        cfg_write(slot_capabilities_offset, exp_caps | 32'h0006_007f);
        repeat (3) @(posedge clk);
        #1 check(msg_count, 1);
        check(power_limit_value, 8'ha5);
        check(power_limit_scale, scale_x0p001);
        cfg_read(slot_capabilities_offset, exp_caps);
        cfg_write(slot_capabilities_offset, 32'h0000_0080);
        repeat (3) @(posedge clk);
        #1 check(msg_count, 1);
        cfg_read(slot_capabilities_offset, exp_caps);
    endtask
    task control_readonly;
        fault_req <= 1'b1;
        cfg_write(slot_control_offset, 32'h0000_ffff);
        cfg_write(slot_control_offset, 32'h0000_0000);
        cfg_read(slot_control_offset, 32'h0000_0000);
        check(slot_power_on, 1'b0);
        check(interlock_toggle, 1'b0);
        check(link_state_notify, 1'b0);
        fault_req <= 1'b0;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            err_count++;
            tally_and_finish;
        end
    end
    initial begin
        rstn = 1'b0;
        {cfg_wr, cfg_rd, fault_req, cfg_addr, cfg_be, cfg_wdata} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        reset_values;
        limit_write_once;
        control_readonly;
        tally_and_finish;
    end
endmodule

// file: verification/slot_partner.sv
`timescale 1ns/1ps
module slot_partner (
    input wire logic clk,
    input wire logic rstn,
    input wire logic power_limit_msg,
    input wire logic fault_req,
    output logic power_fault,
    output logic link_active_change,
    output int msg_count
);
    // Link events keep toggling so any leak into the notify output shows
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            power_fault <= 1'b0;
            link_active_change <= 1'b0;
            msg_count <= 0;
        end else begin
            power_fault <= fault_req;
            link_active_change <= ~link_active_change;
            if (power_limit_msg) begin
                msg_count <= msg_count + 1;
            end
        end
    end
endmodule
